// ### dv/reset_cause_monitor.sv
// Port checker for reset cause logic
`timescale 1ns/100ps
module reset_cause_monitor
  import reset_cause_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic resetPin_n,
  input wire logic powerAboveRise,
  input wire logic powerBelowFall,
  input wire logic watchdogResetReq,
  input wire logic undervoltageBelow,
  input wire logic undervoltageDefaultStart,
  input wire logic internalReset,
  input wire logic undervoltageInterruptRequest,
  input wire logic undervoltageComparatorEnable,
  input wire logic [LEVEL_WIDTH-1:0] undervoltageLevelSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence causeRd;
    rdEn && addr == ADDR_CAUSE;
  endsequence
  sequence ctrlRd;
    rdEn && addr == ADDR_CONTROL;
  endsequence
  wdog_reset_a: assert property (watchdogResetReq |=> internalReset)
    else $error("watchdog request gave no reset");
  pin_reset_a: assert property (!resetPin_n [*3] |=> internalReset)
    else $error("pin gave no reset");
  fall_reset_a: assert property (powerBelowFall [*3] |=> internalReset)
    else $error("supply fall gave no reset");
  cause_format_a: assert property (causeRd |=> rdata[7:5] == 3'h0 && rdata[3:1] == 3'h0)
    else $error("cause reserved bits set");
  read_clear_a: assert property ((causeRd and !watchdogResetReq) ##1
    (!internalReset && !watchdogResetReq) ##1 (causeRd and !internalReset) |=> rdata == 8'h00)
    else $error("cause read did not clear");
  irq_enable_a: assert property (undervoltageInterruptRequest |->
    $past(undervoltageComparatorEnable))
    else $error("interrupt while detector off");
  irq_pulse_a: assert property (undervoltageInterruptRequest |=> !undervoltageInterruptRequest)
    else $error("interrupt longer than a cycle");
  ctrl_format_a: assert property (ctrlRd |=> rdata[6:2] == 5'h00)
    else $error("control reserved bits set");
  rdata_hold_a: assert property (!$past(rdEn) |-> $stable(rdata))
    else $error("read data changed without read");
endmodule
bind reset_cause_and_undervoltage_logic reset_cause_monitor mon (.*);

// ### dv/supply_model.sv
// Supply rail and comparator model
`timescale 1ns/100ps
module supply_model (
  input wire logic clk,
  input wire logic [5:0] vdd,
  input wire logic en,
  input wire logic [3:0] lvl,
  output logic above,
  output logic fall,
  output logic below
);
  logic tog = 1'b0;
  always @(posedge clk) tog <= ~tog;
  assign above = vdd >= 6'h02;
  assign fall = vdd < 6'h02;
  assign below = en ? (vdd < 6'h1f - {2'h0, lvl}) : tog;
endmodule

// ### dv/tb_reset_cause_and_undervoltage_logic.sv
// Self-checking bench for reset cause logic
`timescale 1ns/100ps
module tb_reset_cause_and_undervoltage_logic;
  import reset_cause_pkg::*;
  logic clk = 0, rst = 1, rdEn = 0, wrEn = 0, resetPin_n = 1, watchdogResetReq = 0;
  logic undervoltageDefaultStart = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, mCause;
  logic [5:0] vdd = 6'h28;
  logic powerAboveRise, powerBelowFall, undervoltageBelow, internalReset;
  logic undervoltageInterruptRequest, undervoltageComparatorEnable;
  logic [3:0] undervoltageLevelSelect, lvl;
  int err_total = 0, n_tests = 0, seed = 13003, irqs = 0, irqBase = 0;
  reset_cause_and_undervoltage_logic uut (.clk(clk), .rst(rst), .addr(addr), .rdEn(rdEn),
    .wrEn(wrEn), .wdata(wdata), .rdata(rdata), .resetPin_n(resetPin_n),
    .powerAboveRise(powerAboveRise), .powerBelowFall(powerBelowFall),
    .watchdogResetReq(watchdogResetReq), .undervoltageBelow(undervoltageBelow),
    .undervoltageDefaultStart(undervoltageDefaultStart), .internalReset(internalReset),
    .undervoltageInterruptRequest(undervoltageInterruptRequest),
    .undervoltageComparatorEnable(undervoltageComparatorEnable),
    .undervoltageLevelSelect(undervoltageLevelSelect));
  supply_model sm (.clk(clk), .vdd(vdd), .en(undervoltageComparatorEnable),
    .lvl(undervoltageLevelSelect), .above(powerAboveRise), .fall(powerBelowFall),
    .below(undervoltageBelow));
  initial forever #12.5 clk = ~clk;
  always @(negedge clk) if (undervoltageInterruptRequest === 1'b1) irqs++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    cyc(1);
    wrEn = 1;
    addr = a;
    wdata = v;
    cyc(1);
    wrEn = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    cyc(1);
    rdEn = 1;
    addr = a;
    cyc(1);
    rdEn = 0;
    chk(rdata, exp, what);
  endtask
  task automatic waitRst(input logic v);
    for (int i = 0; i < 60 && internalReset !== v; i++) cyc(1);
    chk({7'h00, internalReset}, {7'h00, v}, "internalReset");
  endtask
  task automatic wdog();
    cyc(1);
    watchdogResetReq = 1;
    cyc(1);
    watchdogResetReq = 0;
    mCause = mCause | 8'h10;
    waitRst(0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    err_total++;
    end_of_test();
  end
  initial begin
    lvl = 4'($random(seed) & 32'h0000_000e);
    mCause = 8'h00;
    cyc(12);
    rst = 0;
    waitRst(0);
    rd(ADDR_CAUSE, 8'h00, "cause");
    wr(ADDR_CAUSE, 8'hff);
    rd(ADDR_CAUSE, 8'h00, "cause");
    rd(16'h0000, 8'h00, "unmapped");
    $display("test power-up done");
    wr(ADDR_CONTROL, 8'h82);
    wdog();
    rd(ADDR_CONTROL, 8'h00, "control");
    wr(ADDR_LEVEL, {4'h0, lvl});
    wr(ADDR_CONTROL, 8'h82);
    vdd = 6'h0a;
    waitRst(1);
    mCause = mCause | 8'h01;
    vdd = 6'h28;
    waitRst(0);
    rd(ADDR_CAUSE, mCause, "cause");
    rd(ADDR_CAUSE, 8'h00, "cause");
    mCause = 8'h00;
    rd(ADDR_CONTROL, 8'h82, "control");
    rd(ADDR_LEVEL, {4'h0, lvl}, "level");
    chk({4'h0, undervoltageLevelSelect}, {4'h0, lvl}, "levelSelect");
    $display("test reset causes done");
    wr(ADDR_CONTROL, 8'h80);
    chk({7'h00, undervoltageComparatorEnable}, 8'h01, "compEnable");
    irqBase = irqs;
    vdd = 6'h0a;
    cyc(8);
    rd(ADDR_CONTROL, 8'h81, "control");
    vdd = 6'h28;
    cyc(8);
    chk(8'(irqs - irqBase), 8'h02, "irqs");
    rd(ADDR_CONTROL, 8'h80, "control");
    wr(ADDR_CONTROL, 8'h00);
    chk({7'h00, undervoltageComparatorEnable}, 8'h00, "compEnable");
    irqBase = irqs;
    cyc(20);
    chk(8'(irqs - irqBase), 8'h00, "irqs");
    rd(ADDR_CONTROL, 8'h00, "control");
    $display("test interrupt done");
    for (int k = 0; k < 2; k++) begin
      wdog();
      if (k == 0) resetPin_n = 0;
      else vdd = 6'h01;
      cyc(4);
      resetPin_n = 1;
      vdd = 6'h28;
      waitRst(0);
      rd(ADDR_CAUSE, 8'h00, "cause");
    end
    mCause = 8'h00;
    $display("test clearing resets done");
    wdog();
    undervoltageDefaultStart = 1;
    vdd = 6'h01;
    cyc(6);
    vdd = 6'h08;
    cyc(8);
    chk({7'h00, internalReset}, 8'h01, "internalReset");
    chk({7'h00, undervoltageComparatorEnable}, 8'h01, "compEnable");
    chk({4'h0, undervoltageLevelSelect}, {4'h0, LEVEL_DEFAULT_START}, "levelSelect");
    vdd = 6'h28;
    waitRst(0);
    undervoltageDefaultStart = 0;
    rd(ADDR_CAUSE, 8'h00, "cause");
    rd(ADDR_CONTROL, 8'h00, "control");
    $display("test default start done");
    end_of_test();
  end
endmodule

// ### verilog/level_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      stage2 <= INIT;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
    end
  end

  assign dout = stage2;
endmodule

// ### verilog/reset_cause_and_undervoltage_logic.sv
// Reset cause register, power sequencing and undervoltage detection
`timescale 1ns/100ps
module reset_cause_and_undervoltage_logic
  import reset_cause_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic resetPin_n,
  input wire logic powerAboveRise,
  input wire logic powerBelowFall,
  input wire logic watchdogResetReq,
  input wire logic undervoltageBelow,
  input wire logic undervoltageDefaultStart,
  output logic internalReset,
  output logic undervoltageInterruptRequest,
  output logic undervoltageComparatorEnable,
  output logic [LEVEL_WIDTH-1:0] undervoltageLevelSelect
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [3:0] syncIn;
  logic [3:0] syncOut;
  logic pinResetS;
  logic riseS;
  logic fallS;
  logic belowS;

  assign syncIn = {~resetPin_n, powerAboveRise, powerBelowFall, undervoltageBelow};

  level_sync #(.WIDTH(4), .INIT(4'b1010)) inSync (
    .clk(clk),
    .rst(rst),
    .din(syncIn),
    .dout(syncOut)
  );

  assign pinResetS = syncOut[3];
  assign riseS = syncOut[2];
  assign fallS = syncOut[1];
  assign belowS = syncOut[0];

  ////////////////////////////////////////////////////////////////////////////
  // State
  power_state_e powerState;
  power_state_e next_powerState;
  logic defaultStart;
  logic next_defaultStart;
  logic [7:0] causeFlags;
  logic [7:0] next_causeFlags;
  logic uvEnable;
  logic next_uvEnable;
  logic uvSelect;
  logic next_uvSelect;
  logic [LEVEL_WIDTH-1:0] uvLevel;
  logic [LEVEL_WIDTH-1:0] next_uvLevel;
  logic belowPrev;
  logic next_belowPrev;
  logic irqPulse;
  logic next_irqPulse;
  logic resetOut;
  logic next_resetOut;
  logic [7:0] readData;
  logic [7:0] next_readData;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources
  logic powerReset;
  logic defaultStartReset;
  logic uvModeReset;
  logic otherReset;
  logic uvFlag;
  logic readCause;
  logic defaultStartActive;

  always_comb begin
    powerReset = (powerState == PWR_OFF) | fallS; // R7
    defaultStartReset = (powerState == PWR_DEFWAIT); // R6
    defaultStartActive = defaultStart & (powerState != PWR_ON); // R8
    uvModeReset = uvEnable & uvSelect & belowS; // R9
    otherReset = pinResetS | powerReset | watchdogResetReq | defaultStartReset; // R17
    uvFlag = uvEnable & belowS; // R16
    readCause = rdEn & (addr == ADDR_CAUSE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and read views
  logic writeAllowed;
  logic readControl;
  logic readLevel;
  logic writeControl;
  logic writeLevel;
  logic [7:0] causeView;
  logic [7:0] controlView;
  logic [7:0] levelView;

  always_comb begin
    writeAllowed = wrEn & ~resetOut & ~otherReset;
    readControl = rdEn & (addr == ADDR_CONTROL);
    readLevel = rdEn & (addr == ADDR_LEVEL);
    writeControl = writeAllowed & (addr == ADDR_CONTROL);
    writeLevel = writeAllowed & (addr == ADDR_LEVEL);
    causeView = 8'h00;
    causeView[CAUSE_WATCHDOG_BIT] = causeFlags[CAUSE_WATCHDOG_BIT]; // R3
    causeView[CAUSE_UNDERVOLT_BIT] = causeFlags[CAUSE_UNDERVOLT_BIT]; // R4
    controlView = 8'h00;
    controlView[CTRL_ENABLE_BIT] = uvEnable; // R15
    controlView[CTRL_SELECT_BIT] = uvSelect; // R11
    controlView[CTRL_FLAG_BIT] = uvFlag; // R12
    levelView = 8'(uvLevel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_powerState = powerState;
    next_defaultStart = defaultStart;
    next_causeFlags = causeFlags;
    next_uvEnable = uvEnable;
    next_uvSelect = uvSelect;
    next_uvLevel = uvLevel;
    next_readData = readData;
    next_belowPrev = belowS;
    next_irqPulse = 1'b0;

    unique case (powerState)
      PWR_OFF: begin
        next_defaultStart = undervoltageDefaultStart;
        if (riseS & ~fallS) begin
          next_powerState = defaultStart ? PWR_DEFWAIT : PWR_ON; // R7 R8
        end
      end
      PWR_DEFWAIT: begin
        if (fallS) begin
          next_powerState = PWR_OFF; // R7
        end else if (~belowS & ~belowPrev) begin
          next_powerState = PWR_ON; // R8
        end
      end
      PWR_ON: begin
        if (fallS) begin
          next_powerState = PWR_OFF; // R7
        end
      end
      default: next_powerState = PWR_OFF;
    endcase

    // Read data and read-clear; hardware sets win over the clear
    if (readCause) begin
      next_readData = causeView; // R1
      next_causeFlags = CAUSE_RESET; // R2
    end else if (readControl) begin
      next_readData = controlView; // R12 R15
    end else if (readLevel) begin
      next_readData = levelView;
    end else if (rdEn) begin
      next_readData = 8'h00;
    end

    if (pinResetS | powerReset | defaultStartReset) begin
      next_causeFlags = CAUSE_RESET; // R2 R6
    end else begin
      if (watchdogResetReq) begin
        next_causeFlags[CAUSE_WATCHDOG_BIT] = 1'b1; // R3 R5
      end
      if (uvModeReset) begin
        next_causeFlags[CAUSE_UNDERVOLT_BIT] = 1'b1; // R4 R5
      end
    end

    // Control writes only outside reset; the flag bit is read-only
    if (otherReset) begin
      next_uvEnable = CONTROL_RESET[CTRL_ENABLE_BIT]; // R17
      next_uvSelect = CONTROL_RESET[CTRL_SELECT_BIT]; // R17
      next_uvLevel = LEVEL_RESET;
    end else if (writeControl) begin
      next_uvEnable = wdata[CTRL_ENABLE_BIT]; // R15
      next_uvSelect = wdata[CTRL_SELECT_BIT]; // R11
    end else if (writeLevel) begin
      next_uvLevel = wdata[LEVEL_WIDTH-1:0]; // R13
    end

    if (uvEnable & ~uvSelect & (belowS != belowPrev)) begin
      next_irqPulse = 1'b1; // R10 R19
    end

    next_resetOut = otherReset | uvModeReset; // R18
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerState <= PWR_OFF;
      defaultStart <= 1'b0;
      causeFlags <= CAUSE_RESET;
      uvEnable <= 1'b0;
      uvSelect <= 1'b0;
      uvLevel <= LEVEL_RESET;
      belowPrev <= 1'b0;
      irqPulse <= 1'b0;
      resetOut <= 1'b1;
      readData <= 8'h00;
    end else begin
      powerState <= next_powerState;
      defaultStart <= next_defaultStart;
      causeFlags <= next_causeFlags;
      uvEnable <= next_uvEnable;
      uvSelect <= next_uvSelect;
      uvLevel <= next_uvLevel;
      belowPrev <= next_belowPrev;
      irqPulse <= next_irqPulse;
      resetOut <= next_resetOut;
      readData <= next_readData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata = readData;
  assign internalReset = resetOut;
  assign undervoltageInterruptRequest = irqPulse;
  assign undervoltageComparatorEnable = uvEnable | defaultStartActive; // R15 R8
  assign undervoltageLevelSelect = defaultStartActive ? LEVEL_DEFAULT_START : uvLevel;
endmodule

// ### verilog/reset_cause_pkg.sv
// Constants for reset cause and undervoltage logic
// Behaviour
// R1: Cause register read-only, full byte reads
// R2: Pin, power-on-clear, cause read clear register
// R3: Bit 4 flags a watchdog reset
// R4: Bit 0 flags an undervoltage reset
// R5: Watchdog/undervoltage resets keep the other flag
// R6: Default-start undervoltage reset clears both flags
// R7: Hold reset until rise, reassert on fall
// R8: Default start holds reset until level reached
// R9: Reset mode: reset while supply below level
// R10: Interrupt mode: request on both crossings
// R11: Control bit 1 selects reset or interrupt
// R12: Control bit 0 shows below-level flag
// R13: Sixteen detection levels passed to comparator
// R14: Software uses only full-byte reads of causes
// R15: Control bit 7 enables the comparator
// R16: Flag zero when above level or disabled
// R17: Non-undervoltage resets clear enable and select
// R18: Internal reset is OR of all requests
// R19: Interrupt pulse only while detector enabled
package reset_cause_pkg;
  localparam logic [15:0] ADDR_CAUSE = 16'hffac;
  localparam logic [15:0] ADDR_CONTROL = 16'hffbe;
  localparam logic [15:0] ADDR_LEVEL = 16'hffbf;
  localparam int CAUSE_WATCHDOG_BIT = 4;
  localparam int CAUSE_UNDERVOLT_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_SELECT_BIT = 1;
  localparam int CTRL_FLAG_BIT = 0;
  localparam int LEVEL_WIDTH = 4;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [3:0] LEVEL_DEFAULT_START = 4'hf;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_DEFWAIT = 2'b01,
    PWR_ON = 2'b10
  } power_state_e;
endpackage
